// >>> logic/acr_params.svh
// register offsets, field positions, reset values and identity defaults of the configuration bank
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
`define ACR_OFS_PORT_SETUP 8'h00
`define ACR_OFS_IDENTITY 8'h01
`define ACR_OFS_GRADE 8'h02
`define ACR_OFS_CHAN_SEL 8'h05
`define ACR_OFS_OP_STATE 8'h08
`define ACR_OFS_CLK_COND 8'h09
`define ACR_OFS_CLK_DIV 8'h0b
`define ACR_OFS_COMMIT 8'hff
`define ACR_RST_PORT_SETUP 8'h18
`define ACR_RST_CHAN_SEL 2'h3
`define ACR_RST_OP_STATE 8'h80
`define ACR_RST_CLK_COND 1'h0
`define ACR_RST_CLK_DIV 3'h0
`define ACR_BIT_LSB_HI 6
`define ACR_BIT_SRST_HI 5
`define ACR_BIT_SRST_LO 2
`define ACR_BIT_LSB_LO 1
`define ACR_PORT_FIXED 8'h18
`define ACR_BIT_COMMIT 0
`define ACR_BIT_DCS 0
`define ACR_GRADE_LSB 4
// arbitrary neutral identity values
`define ACR_DEF_IDENTITY 8'h5a
`define ACR_DEF_GRADE 2'h0
`endif

// >>> logic/acr_pkg.sv
// types shared by the configuration register bank
package acr_pkg;
  // operating state of one converter channel, coded 00..11 in order
  typedef enum logic [1:0] {MODE_RUN, MODE_POWER_DOWN, MODE_STANDBY, MODE_DIG_RESET} acr_mode_t;

  // per-channel operating-state register: bit 7, bits 6:5, bits 1:0
  typedef struct packed {
    logic ext_pd_en;
    logic [1:0] pin_fn;
    acr_mode_t mode;
  } acr_chan_t;
endpackage

// >>> logic/acr_bank.sv
// configuration register bank of a dual-channel converter with shadowed program registers
//
// Contract
// - port-setup register mirrors bit-order and soft-reset bits in both nibbles; resets 0x18
// - read-only identity register returns a fixed code; writes do nothing
// - channel-select bit 0 is channel A, bit 1 channel B; reset selects both
// - operating-state low bits: run, power-down, standby, chip digital reset, per channel
// - clock divider field divides sample clock by value plus one; global; resets to zero, dividing by one
// - shadowed writes act only after transfer write of 0x01; bit then self-clears
// - reading a per-channel register with both channels selected returns channel A
// - bit order defaults to most significant bit first after power-up
`timescale 1ns/1ns
`default_nettype none
`include "acr_params.svh"
module acr_bank #(
  parameter logic [7:0] CHIP_IDENTITY = `ACR_DEF_IDENTITY, // arbitrary value
  parameter logic [1:0] SPEED_GRADE = `ACR_DEF_GRADE // arbitrary value
) (
  input wire logic CLK_SYS, // system clock, 20 MHz
  input wire logic ARST_N, // asynchronous reset, active low
  input wire logic [7:0] REG_ADDR, // register address from the serial port
  input wire logic [7:0] REG_WDATA, // write data, already in register bit order
  input wire logic REG_WR, // one-cycle write strobe
  input wire logic REG_RD, // one-cycle read strobe
  output logic [7:0] REG_RDATA, // read data, valid the cycle after REG_RD
  output logic LSB_FIRST, // serial bit order: high for least significant first
  output acr_pkg::acr_chan_t CHAN_A_CFG, // applied state of channel A
  output acr_pkg::acr_chan_t CHAN_B_CFG, // applied state of channel B
  output logic DCS_EN, // applied duty-cycle stabilizer enable
  output logic [2:0] CLK_DIV, // applied divider field, ratio is value plus one
  output logic DIV_TICK // one pulse per divided sample clock period
);
  import acr_pkg::*;

  logic lsb_first, next_lsb_first;
  logic soft_rst, next_soft_rst;
  logic [1:0] chan_sel, next_chan_sel;
  logic commit, next_commit;
  acr_chan_t shadow_a, next_shadow_a, shadow_b, next_shadow_b;
  logic shadow_dcs, next_shadow_dcs;
  logic [2:0] shadow_div, next_shadow_div;
  acr_chan_t active_a, next_active_a, active_b, next_active_b;
  logic active_dcs, next_active_dcs;
  logic [2:0] active_div, next_active_div;
  logic [2:0] div_cnt, next_div_cnt;
  logic [7:0] rdata, next_rdata;
  logic wr_setup, wr_sel, wr_mode, wr_cond, wr_div, wr_commit;

  // packs a channel state into its register image
  function automatic logic [7:0] chan_image(input acr_chan_t c);
    chan_image = {c.ext_pd_en, c.pin_fn, 3'h0, c.mode};
  endfunction

  // unpacks a register image into a channel state
  function automatic acr_chan_t chan_from(input logic [7:0] d);
    chan_from = '{ext_pd_en: d[7], pin_fn: d[6:5], mode: acr_mode_t'(d[1:0])};
  endfunction

  localparam acr_chan_t CHAN_RST = chan_from(`ACR_RST_OP_STATE);

  // address decode of write strobes
  assign wr_setup = REG_WR && (REG_ADDR == `ACR_OFS_PORT_SETUP);
  assign wr_sel = REG_WR && (REG_ADDR == `ACR_OFS_CHAN_SEL);
  assign wr_mode = REG_WR && (REG_ADDR == `ACR_OFS_OP_STATE);
  assign wr_cond = REG_WR && (REG_ADDR == `ACR_OFS_CLK_COND);
  assign wr_div = REG_WR && (REG_ADDR == `ACR_OFS_CLK_DIV);
  assign wr_commit = REG_WR && (REG_ADDR == `ACR_OFS_COMMIT);

  // next values of the control and shadow registers
  always_comb
  begin
    next_lsb_first = lsb_first;
    next_soft_rst = 1'b0;
    next_chan_sel = chan_sel;
    next_commit = 1'b0;
    next_shadow_a = shadow_a;
    next_shadow_b = shadow_b;
    next_shadow_dcs = shadow_dcs;
    next_shadow_div = shadow_div;
    next_active_a = active_a;
    next_active_b = active_b;
    next_active_dcs = active_dcs;
    next_active_div = active_div;
    if (soft_rst)
    begin
      // a pending soft reset restores every default and drops its own bits
      next_lsb_first = 1'b0;
      next_chan_sel = `ACR_RST_CHAN_SEL;
      next_shadow_a = CHAN_RST;
      next_shadow_b = CHAN_RST;
      next_shadow_dcs = `ACR_RST_CLK_COND;
      next_shadow_div = `ACR_RST_CLK_DIV;
      next_active_a = CHAN_RST;
      next_active_b = CHAN_RST;
      next_active_dcs = `ACR_RST_CLK_COND;
      next_active_div = `ACR_RST_CLK_DIV;
    end
    else
    begin
      // either nibble sets the bit, so the register reads the same in both shift orders
      if (wr_setup)
      begin
        next_lsb_first = REG_WDATA[`ACR_BIT_LSB_HI] | REG_WDATA[`ACR_BIT_LSB_LO];
        next_soft_rst = REG_WDATA[`ACR_BIT_SRST_HI] | REG_WDATA[`ACR_BIT_SRST_LO];
      end
      if (wr_sel)
        next_chan_sel = REG_WDATA[1:0];
      // per-channel write goes to every selected channel
      if (wr_mode && chan_sel[0])
        next_shadow_a = chan_from(REG_WDATA);
      if (wr_mode && chan_sel[1])
        next_shadow_b = chan_from(REG_WDATA);
      if (wr_cond)
        next_shadow_dcs = REG_WDATA[`ACR_BIT_DCS];
      if (wr_div)
        next_shadow_div = REG_WDATA[2:0];
      if (wr_commit)
        next_commit = REG_WDATA[`ACR_BIT_COMMIT];
      // all shadows move to the applied copies in one edge, then the bit reads back zero
      if (commit)
      begin
        next_active_a = shadow_a;
        next_active_b = shadow_b;
        next_active_dcs = shadow_dcs;
        next_active_div = shadow_div;
      end
    end
  end

  // control and shadow registers
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      lsb_first <= 1'b0;
      soft_rst <= 1'b0;
      chan_sel <= `ACR_RST_CHAN_SEL;
      commit <= 1'b0;
      shadow_a <= CHAN_RST;
      shadow_b <= CHAN_RST;
      shadow_dcs <= `ACR_RST_CLK_COND;
      shadow_div <= `ACR_RST_CLK_DIV;
      active_a <= CHAN_RST;
      active_b <= CHAN_RST;
      active_dcs <= `ACR_RST_CLK_COND;
      active_div <= `ACR_RST_CLK_DIV;
    end
    else
    begin
      lsb_first <= next_lsb_first;
      soft_rst <= next_soft_rst;
      chan_sel <= next_chan_sel;
      commit <= next_commit;
      shadow_a <= next_shadow_a;
      shadow_b <= next_shadow_b;
      shadow_dcs <= next_shadow_dcs;
      shadow_div <= next_shadow_div;
      active_a <= next_active_a;
      active_b <= next_active_b;
      active_dcs <= next_active_dcs;
      active_div <= next_active_div;
    end
  end

  // read mux; unmapped addresses and open bits read zero
  always_comb
  begin
    next_rdata = rdata;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        `ACR_OFS_PORT_SETUP:
          next_rdata = `ACR_PORT_FIXED | {1'b0, lsb_first, soft_rst, 2'h0, soft_rst, lsb_first, 1'b0};
        `ACR_OFS_IDENTITY: next_rdata = CHIP_IDENTITY;
        `ACR_OFS_GRADE: next_rdata = {2'h0, SPEED_GRADE, 4'h0};
        `ACR_OFS_CHAN_SEL: next_rdata = {6'h0, chan_sel};
        // channel A wins whenever its select bit is set, including both selected
        `ACR_OFS_OP_STATE:
          next_rdata = (chan_sel[0] || !chan_sel[1]) ? chan_image(shadow_a) : chan_image(shadow_b);
        `ACR_OFS_CLK_COND: next_rdata = {7'h0, shadow_dcs};
        `ACR_OFS_CLK_DIV: next_rdata = {5'h0, shadow_div};
        `ACR_OFS_COMMIT: next_rdata = {7'h0, commit};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // divided sample clock: one tick every active_div+1 cycles; >= guards a ratio cut mid-count
  always_comb
  begin
    next_div_cnt = (div_cnt >= active_div) ? 3'h0 : div_cnt + 3'h1;
  end

  // read data and divider counter
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rdata <= 8'h00;
      div_cnt <= 3'h0;
    end
    else
    begin
      rdata <= next_rdata;
      div_cnt <= next_div_cnt;
    end
  end

  assign REG_RDATA = rdata;
  assign LSB_FIRST = lsb_first;
  assign CHAN_A_CFG = active_a;
  assign CHAN_B_CFG = active_b;
  assign DCS_EN = active_dcs;
  assign CLK_DIV = active_div;
  assign DIV_TICK = (div_cnt >= active_div);

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  sequence s_commit_applied;
    (CLK_DIV == $past(shadow_div)) && (CHAN_A_CFG == $past(shadow_a));
  endsequence

  sequence s_defaults_back;
    !LSB_FIRST && (chan_sel == 2'h3) && (CLK_DIV == 3'h0) && !soft_rst;
  endsequence

  // mirrored nibbles and the fixed ones of the port-setup image
  port_mirror_a: assert property (REG_RD && REG_ADDR == `ACR_OFS_PORT_SETUP
    |=> REG_RDATA[4:3] == 2'b11 && REG_RDATA[6] == REG_RDATA[1] && REG_RDATA[5] == REG_RDATA[2])
    else $error("port setup not mirrored");
  identity_read_a: assert property (REG_RD && REG_ADDR == `ACR_OFS_IDENTITY
    |=> REG_RDATA == CHIP_IDENTITY)
    else $error("identity wrong");
  both_chan_write_a: assert property (REG_WR && REG_ADDR == `ACR_OFS_OP_STATE && chan_sel == 2'h3 && !soft_rst
    |=> shadow_a == shadow_b)
    else $error("both channels not written");
  dig_reset_mode_a: assert property (wr_mode && chan_sel[0] && REG_WDATA[1:0] == 2'b11 && !soft_rst
    |=> shadow_a.mode == MODE_DIG_RESET)
    else $error("mode code wrong");
  div_spacing_a: assert property (DIV_TICK && active_div == 3'h1 && !commit && !REG_WR && !soft_rst
    |=> !DIV_TICK ##1 (DIV_TICK || $past(REG_WR)))
    else $error("divider ratio wrong");
  shadow_hold_a: assert property (wr_div && !commit && !soft_rst
    |=> $stable(CLK_DIV))
    else $error("shadow write leaked");
  commit_apply_a: assert property (commit && !soft_rst
    |=> s_commit_applied ##0 (!commit || $past(wr_commit)))
    else $error("commit not applied");
  read_chan_a_a: assert property (REG_RD && REG_ADDR == `ACR_OFS_OP_STATE && chan_sel == 2'h3
    |=> REG_RDATA == chan_image($past(shadow_a)))
    else $error("both-selected read not A");
  soft_reset_a: assert property (wr_setup && REG_WDATA[`ACR_BIT_SRST_HI] && !soft_rst
    |=> soft_rst ##1 s_defaults_back)
    else $error("soft reset incomplete");
endmodule
`default_nettype wire

// >>> tb/acr_host.sv
// host-side model that issues accesses on the parallel register port
`timescale 1ns/1ns
`default_nettype none
module acr_host (
  input wire logic clk, // system clock
  output logic [7:0] addr, // register address
  output logic [7:0] wdata, // write data
  output logic wr, // write strobe
  output logic rd, // read strobe
  input wire logic [7:0] rdata // read data
);
  // idle at time zero
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle write; released lines show the inverse so stale values never look valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  // one-cycle read; data is taken half a cycle after the sampling edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
  // transfer command, then wait for the applied outputs to move
  task automatic commit();
    wr_reg(8'hff, 8'h01);
    @(posedge clk);
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/acr_bank_tb.sv
// self-checking testbench of the configuration register bank
`timescale 1ns/1ns
`default_nettype none
module acr_bank_tb;
  import acr_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // arbitrary value
  logic clk_sys, arst_n, wr, rd, lsb_first, dcs_en, div_tick;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] clk_div;
  acr_chan_t cha, chb;
  int err_total = 0;
  int cmp_count = 0;
  acr_bank #(.CHIP_IDENTITY(ID), .SPEED_GRADE(2'h2)) u_acr_bank (.CLK_SYS(clk_sys), .ARST_N(arst_n),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .LSB_FIRST(lsb_first),
    .CHAN_A_CFG(cha), .CHAN_B_CFG(chb), .DCS_EN(dcs_en), .CLK_DIV(clk_div), .DIV_TICK(div_tick));
  acr_host u_acr_host (.clk(clk_sys), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_acr_host.rd_reg(a, d);
    chk(d, exp);
  endtask
  task automatic t_reset();
    @(negedge clk_sys);
    chk({7'h0, lsb_first}, 8'h00);
    chk({3'h0, cha}, 8'h10);
    chk({4'h0, dcs_en, clk_div}, 8'h00);
    chk({7'h0, div_tick}, 8'h01);
    rchk(8'h00, 8'h18);
    rchk(8'h05, 8'h03);
    rchk(8'h08, 8'h80);
  endtask
  // read-only places and an unmapped address ignore writes
  task automatic t_readonly();
    u_acr_host.wr_reg(8'h01, ~ID);
    u_acr_host.wr_reg(8'h02, 8'hff);
    u_acr_host.wr_reg(8'h33, 8'h77);
    rchk(8'h01, ID);
    rchk(8'h02, 8'h20);
    rchk(8'h33, 8'h00);
  endtask
  task automatic t_divider();
    int n;
    u_acr_host.wr_reg(8'h0b, 8'h07);
    u_acr_host.wr_reg(8'h09, 8'h01);
    @(negedge clk_sys);
    chk({4'h0, dcs_en, clk_div}, 8'h00);
    rchk(8'h0b, 8'h07);
    rchk(8'h09, 8'h01);
    u_acr_host.commit();
    chk({4'h0, dcs_en, clk_div}, 8'h0f);
    rchk(8'hff, 8'h00);
    n = 0;
    repeat (16)
    begin
      @(negedge clk_sys);
      n += int'(div_tick);
    end
    chk(n[7:0], 8'h02);
    // divide by two gives a tick every other cycle
    u_acr_host.wr_reg(8'h0b, 8'h01);
    u_acr_host.commit();
    n = 0;
    repeat (16)
    begin
      @(negedge clk_sys);
      n += int'(div_tick);
    end
    chk(n[7:0], 8'h08);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      u_acr_host.wr_reg(8'h08, m[7:0]);
      u_acr_host.commit();
      chk({3'h0, cha}, m[7:0]);
      chk({3'h0, chb}, m[7:0]);
    end
    u_acr_host.wr_reg(8'h05, 8'h01);
    u_acr_host.wr_reg(8'h08, 8'h61);
    u_acr_host.wr_reg(8'h05, 8'h02);
    u_acr_host.wr_reg(8'h08, 8'h82);
    u_acr_host.commit();
    chk({3'h0, cha}, 8'h0d);
    chk({3'h0, chb}, 8'h12);
    rchk(8'h08, 8'h82);
    u_acr_host.wr_reg(8'h05, 8'h03);
    rchk(8'h08, 8'h61);
  endtask
  // bit order first, then soft reset must undo everything set so far
  task automatic t_port();
    u_acr_host.wr_reg(8'h00, 8'h42);
    @(negedge clk_sys);
    chk({7'h0, lsb_first}, 8'h01);
    rchk(8'h00, 8'h5a);
    // leave the select off its default, and set bit order with the reset so only the reset can clear it
    u_acr_host.wr_reg(8'h05, 8'h01);
    u_acr_host.wr_reg(8'h00, 8'h66);
    repeat (2) @(negedge clk_sys);
    chk({7'h0, lsb_first}, 8'h00);
    chk({3'h0, cha}, 8'h10);
    chk({4'h0, dcs_en, clk_div}, 8'h00);
    rchk(8'h00, 8'h18);
    rchk(8'h05, 8'h03);
    rchk(8'h0b, 8'h00);
    rchk(8'h08, 8'h80);
    rchk(8'h09, 8'h00);
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    arst_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_readonly();
    t_divider();
    t_modes();
    t_port();
    wrap_up();
  end
  // whole run is about 128 cycles; this limit of 4000 cycles is over thirty times that
  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
